// ### hdl/bsd_boot_strap_decoder.sv
// Boot strap decoder: samples strap pins at reset and decodes the fields
//
// Contract
// - Sixteen strap pins sampled after reset release
// - Low five bits select boot list
// - Bit 5 enables oscillator clock output
// - Bits 7:6 select MAC interface mode
// - Bit 8 selects 8/16-bit memory width
// - Bit 9 selects ECC owner for NAND
// - Bits 11:10 select memory bus multiplexing
// - Bits 15:14 give crystal frequency
// - Status holds straps at 23:16, 7:0
// - Peripheral sources skipped after warm reset
// - Memory sources searched after any reset
// - Code 10011: NAND, NAND-I2C, card0, serial0
// - Code 11100: card1, card0, serial0, usb_port0
// - Default bits 7:5 are 011
// - Default bits 15:8 are 10000000
// - Codes 00010, 00110, 10111 order map
// - Codes 01011, 11000, 11001 order map
// - Codes 10010, 10100, 10110 order map
module bsd_boot_strap_decoder (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic [15:0] display_data_pins,
	input  wire logic        warm_reset,
	output logic      [23:0] strap_status_q,
	output logic             strap_valid_q,
	output logic             osc_clock_out_en_q,
	output logic      [1:0]  mac_boot_mode_q,
	output logic             mem_width16_q,
	output logic             ecc_by_device_q,
	output logic      [1:0]  mem_mux_mode_q,
	output logic      [1:0]  xtal_sel_q,
	output logic             rsvd_error_q,
	output logic      [3:0]  boot_dev0_q,
	output logic      [3:0]  boot_dev1_q,
	output logic      [3:0]  boot_dev2_q,
	output logic      [3:0]  boot_dev3_q,
	output logic             order_known_q
);
	// Synchroniser stages for the strap pins
	logic [15:0] sync1_q;
	logic [15:0] sync2_q;
	// Captured strap word
	logic [15:0] strap_q;
	// Warm flag captured in LATCH with the straps
	logic        warm_q;
	// Settle counter after release
	logic [1:0]  settle_q;
	// Sequencer state
	bsd_pkg::bsd_state_t state_q;
	// Decoded order, combinational
	logic [3:0]  dev_d [4];
	logic        known_d;

	// Two-flop synchroniser; pins come from outside the clock domain
	always_ff @(posedge clk) begin
		sync1_q <= display_data_pins;
		sync2_q <= sync1_q;
	end

	// Sequencer: hold during reset, settle, latch once, then freeze
	always_ff @(posedge clk) begin
		if (srst) begin
			state_q  <= bsd_pkg::BSD_ST_RESET;
			settle_q <= '0;
		end else begin
			unique case (state_q)
				bsd_pkg::BSD_ST_RESET: begin
					state_q <= bsd_pkg::BSD_ST_SYNC;
				end
				bsd_pkg::BSD_ST_SYNC: begin
					// Wait so the synchroniser holds post-release samples
					settle_q <= settle_q + 2'h1;
					if (settle_q == bsd_pkg::SETTLE_CNT) begin
						state_q <= bsd_pkg::BSD_ST_LATCH;
					end
				end
				bsd_pkg::BSD_ST_LATCH: begin
					state_q <= bsd_pkg::BSD_ST_DONE;
				end
				bsd_pkg::BSD_ST_DONE: begin
					state_q <= bsd_pkg::BSD_ST_DONE;
				end
			endcase
		end
	end

	// Strap capture; reset loads constants only, pins taken in LATCH
	always_ff @(posedge clk) begin
		if (srst) begin
			strap_q <= '0;
			warm_q  <= 1'b0;
		end else if (state_q == bsd_pkg::BSD_ST_LATCH) begin
			strap_q <= sync2_q;
			warm_q  <= warm_reset;
		end
	end

	// Boot order decoder; unlisted codes give an empty list
	always_comb begin
		dev_d[0] = bsd_pkg::BSD_SRC_NONE;
		dev_d[1] = bsd_pkg::BSD_SRC_NONE;
		dev_d[2] = bsd_pkg::BSD_SRC_NONE;
		dev_d[3] = bsd_pkg::BSD_SRC_NONE;
		known_d  = 1'b1;
		case (strap_q[bsd_pkg::ORDER_LSB +: bsd_pkg::ORDER_W])
			bsd_pkg::ORD_02: begin
				dev_d[0] = bsd_pkg::BSD_SRC_SERIAL0;
				dev_d[1] = bsd_pkg::BSD_SRC_SPI_PORT0;
				dev_d[2] = bsd_pkg::BSD_SRC_NAND;
				dev_d[3] = bsd_pkg::BSD_SRC_NAND_OVER_I2C_BOOT;
			end
			bsd_pkg::ORD_06: begin
				dev_d[0] = bsd_pkg::BSD_SRC_MAC1;
				dev_d[1] = bsd_pkg::BSD_SRC_SPI_PORT0;
				dev_d[2] = bsd_pkg::BSD_SRC_NAND;
				dev_d[3] = bsd_pkg::BSD_SRC_NAND_OVER_I2C_BOOT;
			end
			bsd_pkg::ORD_17: begin
				dev_d[0] = bsd_pkg::BSD_SRC_CARD0;
				dev_d[1] = bsd_pkg::BSD_SRC_SPI_PORT0;
				dev_d[2] = bsd_pkg::BSD_SRC_SERIAL0;
				dev_d[3] = bsd_pkg::BSD_SRC_USB_PORT0;
			end
			bsd_pkg::ORD_0B: begin
				dev_d[0] = bsd_pkg::BSD_SRC_USB_PORT0;
				dev_d[1] = bsd_pkg::BSD_SRC_NAND;
				dev_d[2] = bsd_pkg::BSD_SRC_SPI_PORT0;
				dev_d[3] = bsd_pkg::BSD_SRC_CARD0;
			end
			bsd_pkg::ORD_18: begin
				dev_d[0] = bsd_pkg::BSD_SRC_SPI_PORT0;
				dev_d[1] = bsd_pkg::BSD_SRC_CARD0;
				dev_d[2] = bsd_pkg::BSD_SRC_USB_PORT0;
				dev_d[3] = bsd_pkg::BSD_SRC_SERIAL0;
			end
			bsd_pkg::ORD_19: begin
				dev_d[0] = bsd_pkg::BSD_SRC_SPI_PORT0;
				dev_d[1] = bsd_pkg::BSD_SRC_CARD0;
				dev_d[2] = bsd_pkg::BSD_SRC_MAC1;
				dev_d[3] = bsd_pkg::BSD_SRC_SERIAL0;
			end
			bsd_pkg::ORD_12: begin
				dev_d[0] = bsd_pkg::BSD_SRC_NAND;
				dev_d[1] = bsd_pkg::BSD_SRC_NAND_OVER_I2C_BOOT;
				dev_d[2] = bsd_pkg::BSD_SRC_USB_PORT0;
				dev_d[3] = bsd_pkg::BSD_SRC_SERIAL0;
			end
			bsd_pkg::ORD_14: begin
				dev_d[0] = bsd_pkg::BSD_SRC_NAND;
				dev_d[1] = bsd_pkg::BSD_SRC_NAND_OVER_I2C_BOOT;
				dev_d[2] = bsd_pkg::BSD_SRC_SPI_PORT0;
				dev_d[3] = bsd_pkg::BSD_SRC_MAC1;
			end
			bsd_pkg::ORD_16: begin
				dev_d[0] = bsd_pkg::BSD_SRC_SPI_PORT0;
				dev_d[1] = bsd_pkg::BSD_SRC_CARD0;
				dev_d[2] = bsd_pkg::BSD_SRC_SERIAL0;
				dev_d[3] = bsd_pkg::BSD_SRC_MAC1;
			end
			bsd_pkg::ORD_13: begin
				dev_d[0] = bsd_pkg::BSD_SRC_NAND;
				dev_d[1] = bsd_pkg::BSD_SRC_NAND_OVER_I2C_BOOT;
				dev_d[2] = bsd_pkg::BSD_SRC_CARD0;
				dev_d[3] = bsd_pkg::BSD_SRC_SERIAL0;
			end
			bsd_pkg::ORD_1C: begin
				dev_d[0] = bsd_pkg::BSD_SRC_CARD1;
				dev_d[1] = bsd_pkg::BSD_SRC_CARD0;
				dev_d[2] = bsd_pkg::BSD_SRC_SERIAL0;
				dev_d[3] = bsd_pkg::BSD_SRC_USB_PORT0;
			end
			default: begin
				known_d = 1'b0;
			end
		endcase
	end

	// Peripheral sources need a host to poll; not offered after warm reset
	// SPI flash is a memory source here, so it is kept after a warm reset
	function automatic logic is_periph(input logic [3:0] s);
		is_periph = (s == bsd_pkg::BSD_SRC_SERIAL0) ||
			(s == bsd_pkg::BSD_SRC_USB_PORT0) || (s == bsd_pkg::BSD_SRC_MAC1);
	endfunction

	// Registered decode outputs, updated once at DONE entry
	always_ff @(posedge clk) begin
		if (srst) begin
			strap_status_q     <= '0;
			strap_valid_q      <= 1'b0;
			osc_clock_out_en_q <= 1'b0;
			mac_boot_mode_q    <= '0;
			mem_width16_q      <= 1'b0;
			ecc_by_device_q    <= 1'b0;
			mem_mux_mode_q     <= '0;
			xtal_sel_q         <= '0;
			rsvd_error_q       <= 1'b0;
			boot_dev0_q        <= bsd_pkg::BSD_SRC_NONE;
			boot_dev1_q        <= bsd_pkg::BSD_SRC_NONE;
			boot_dev2_q        <= bsd_pkg::BSD_SRC_NONE;
			boot_dev3_q        <= bsd_pkg::BSD_SRC_NONE;
			order_known_q      <= 1'b0;
		end else if (state_q == bsd_pkg::BSD_ST_DONE && !strap_valid_q) begin
			strap_valid_q <= 1'b1;
			strap_status_q <= {strap_q[15:8], 8'h00, strap_q[7:0]};
			osc_clock_out_en_q <= strap_q[bsd_pkg::CLKOUT_BIT];
			mac_boot_mode_q <= strap_q[bsd_pkg::MACMODE_LSB +: 2];
			mem_width16_q <= strap_q[bsd_pkg::MEMWIDTH_BIT];
			ecc_by_device_q <= strap_q[bsd_pkg::ECCOWN_BIT];
			mem_mux_mode_q <= strap_q[bsd_pkg::MUX_LSB +: 2];
			xtal_sel_q <= strap_q[bsd_pkg::XTAL_LSB +: 2];
			rsvd_error_q <= strap_q[bsd_pkg::RSVD_LSB +: 2] != bsd_pkg::RSVD_OK;
			order_known_q <= known_d;
			boot_dev0_q <= (warm_q && is_periph(dev_d[0])) ?
				bsd_pkg::BSD_SRC_NONE : dev_d[0];
			boot_dev1_q <= (warm_q && is_periph(dev_d[1])) ?
				bsd_pkg::BSD_SRC_NONE : dev_d[1];
			boot_dev2_q <= (warm_q && is_periph(dev_d[2])) ?
				bsd_pkg::BSD_SRC_NONE : dev_d[2];
			boot_dev3_q <= (warm_q && is_periph(dev_d[3])) ?
				bsd_pkg::BSD_SRC_NONE : dev_d[3];
		end
	end

	// Checks
	// frozen value
	property p_frozen;
		@(posedge clk) disable iff (srst)
		strap_valid_q |=> $stable(strap_status_q);
	endproperty
	a_frozen: assert property (p_frozen) else $error("status moved");
	property p_status;
		@(posedge clk) disable iff (srst)
		strap_valid_q |-> strap_status_q[23:16] == strap_q[15:8] &&
			strap_status_q[7:0] == strap_q[7:0] && strap_status_q[15:8] == 8'h00;
	endproperty
	a_status: assert property (p_status) else $error("status bad");
	property p_valid_time;
		@(posedge clk) $fell(srst) |-> !strap_valid_q [*6] ##1 strap_valid_q;
	endproperty
	a_valid_time: assert property (p_valid_time) else $error("valid late");
	property p_clkout;
		@(posedge clk) disable iff (srst)
		strap_valid_q |-> osc_clock_out_en_q == strap_status_q[5];
	endproperty
	a_clkout: assert property (p_clkout) else $error("clkout bad");
	property p_mac;
		@(posedge clk) disable iff (srst)
		strap_valid_q |-> mac_boot_mode_q == strap_status_q[7:6];
	endproperty
	a_mac: assert property (p_mac) else $error("mac mode bad");
	property p_xtal;
		@(posedge clk) disable iff (srst)
		strap_valid_q |-> xtal_sel_q == strap_status_q[23:22];
	endproperty
	a_xtal: assert property (p_xtal) else $error("xtal bad");
	property p_nand;
		@(posedge clk) disable iff (srst)
		strap_valid_q && !warm_q && strap_status_q[4:0] == 5'h13 |->
			boot_dev0_q == bsd_pkg::BSD_SRC_NAND &&
			boot_dev3_q == bsd_pkg::BSD_SRC_SERIAL0;
	endproperty
	a_nand: assert property (p_nand) else $error("nand order bad");
	property p_warm;
		@(posedge clk) disable iff (srst)
		strap_valid_q && warm_q |-> boot_dev0_q != bsd_pkg::BSD_SRC_USB_PORT0 &&
			boot_dev3_q != bsd_pkg::BSD_SRC_SERIAL0;
	endproperty
	a_warm: assert property (p_warm) else $error("warm periph");
	property p_width;
		@(posedge clk) disable iff (srst)
		strap_valid_q |-> mem_width16_q == strap_status_q[16];
	endproperty
	a_width: assert property (p_width) else $error("width bad");
	c_emmc: cover property (@(posedge clk)
		strap_valid_q && strap_status_q[4:0] == 5'h1c);
	c_warm: cover property (@(posedge clk) strap_valid_q && warm_q);
	c_unknown: cover property (@(posedge clk) strap_valid_q && !order_known_q);
endmodule

// ### hdl/bsd_pkg.sv
// Package of constants and types for the boot strap decoder
package bsd_pkg;
	// Strap word width and field positions
	localparam int STRAP_W       = 16;
	localparam int ORDER_LSB     = 0;
	localparam int ORDER_W       = 5;
	localparam int CLKOUT_BIT    = 5;
	localparam int MACMODE_LSB   = 6;
	localparam int MEMWIDTH_BIT  = 8;
	localparam int ECCOWN_BIT    = 9;
	localparam int MUX_LSB       = 10;
	localparam int RSVD_LSB      = 12;
	localparam int XTAL_LSB      = 14;
	// Status word layout: high strap byte at 23:16, low byte at 7:0
	localparam int STAT_W        = 24;
	localparam int STAT_HI_LSB   = 16;
	// Strap defaults of the module
	localparam logic [2:0] DFLT_7_5  = 3'h3;
	localparam logic [7:0] DFLT_15_8 = 8'h80;
	localparam logic [1:0] RSVD_OK   = 2'h0;
	// Boot source codes, one per device slot
	typedef enum logic [3:0] {
		BSD_SRC_NONE    = 4'h0,
		BSD_SRC_NAND    = 4'h1,
		BSD_SRC_NAND_OVER_I2C_BOOT = 4'h2,
		BSD_SRC_CARD0   = 4'h3,
		BSD_SRC_CARD1   = 4'h4,
		BSD_SRC_SERIAL0 = 4'h5,
		BSD_SRC_SPI_PORT0    = 4'h6,
		BSD_SRC_USB_PORT0    = 4'h7,
		BSD_SRC_MAC1    = 4'h8
	} bsd_src_t;
	// Boot order codes supported on the module
	localparam logic [4:0] ORD_02 = 5'h02;
	localparam logic [4:0] ORD_06 = 5'h06;
	localparam logic [4:0] ORD_0B = 5'h0b;
	localparam logic [4:0] ORD_12 = 5'h12;
	localparam logic [4:0] ORD_13 = 5'h13;
	localparam logic [4:0] ORD_14 = 5'h14;
	localparam logic [4:0] ORD_16 = 5'h16;
	localparam logic [4:0] ORD_17 = 5'h17;
	localparam logic [4:0] ORD_18 = 5'h18;
	localparam logic [4:0] ORD_19 = 5'h19;
	localparam logic [4:0] ORD_1C = 5'h1c;
	// Sequencer states
	typedef enum logic [3:0] {
		BSD_ST_RESET = 4'b0001,
		BSD_ST_SYNC  = 4'b0010,
		BSD_ST_LATCH = 4'b0100,
		BSD_ST_DONE  = 4'b1000
	} bsd_state_t;
	// Sync settle count after reset release
	localparam logic [1:0] SETTLE_CNT = 2'h2;
endpackage

// ### bench/bsd_strap_model.sv
// Strap resistor model: module pull network with carrier overrides
module bsd_strap_model #(
	parameter logic [4:0] ORDER_DFLT = 5'h13 // Module boot order pulls
) (
	input  wire logic [15:0] ovr_en,  // Carrier resistor fitted on pin
	input  wire logic [15:0] ovr_val, // Level the carrier resistor pulls to
	output logic      [15:0] pins     // Level seen at the strap pins
);
	timeunit 1ns;
	timeprecision 1ps;

	// Pull pattern of the module; reserved pair is pulled to zero
	logic [15:0] dflt; // On-module default levels

	assign dflt = {8'h80, 3'h3, ORDER_DFLT};

	// A fitted carrier resistor is stronger than the module pull, so it wins
	// carrier override
	assign pins = (ovr_en & ovr_val) | (~ovr_en & dflt);
endmodule

// ### bench/bsd_boot_strap_decoder_bench.sv
// Self-checking bench for the boot strap decoder
module bsd_boot_strap_decoder_bench;
	timeunit 1ns;
	timeprecision 1ps;

	// Short names for the source codes used in the expected lists
	localparam logic [3:0] NA = bsd_pkg::BSD_SRC_NAND;
	localparam logic [3:0] NI = bsd_pkg::BSD_SRC_NAND_OVER_I2C_BOOT;
	localparam logic [3:0] C0 = bsd_pkg::BSD_SRC_CARD0;
	localparam logic [3:0] C1 = bsd_pkg::BSD_SRC_CARD1;
	localparam logic [3:0] SE = bsd_pkg::BSD_SRC_SERIAL0;
	localparam logic [3:0] SP = bsd_pkg::BSD_SRC_SPI_PORT0;
	localparam logic [3:0] US = bsd_pkg::BSD_SRC_USB_PORT0;
	localparam logic [3:0] MA = bsd_pkg::BSD_SRC_MAC1;

	logic        clk, srst, warm_reset;       // Clock, reset, warm flag
	logic [15:0] ovr_en, ovr_val, pins;       // Carrier straps and pin level
	logic [23:0] status;                      // Captured strap status
	logic        valid, clko, w16, ecc, rsvd; // Single-bit decodes
	logic        known;                       // Order code is listed
	logic [1:0]  mac, mux, xtal;              // Two-bit decodes
	logic [3:0]  d0, d1, d2, d3;              // Boot list slots
	int          n_errors = 0;                // Mismatches seen
	int          checks = 0;                  // Comparisons made

	// Listed order codes and their device lists, first slot in high nibble
	logic [4:0]  codes [11] = '{5'h02, 5'h06, 5'h0b, 5'h12, 5'h13, 5'h14,
		5'h16, 5'h17, 5'h18, 5'h19, 5'h1c};
	logic [15:0] lists [11] = '{{SE, SP, NA, NI}, {MA, SP, NA, NI},
		{US, NA, SP, C0}, {NA, NI, US, SE}, {NA, NI, C0, SE},
		{NA, NI, SP, MA}, {SP, C0, SE, MA}, {C0, SP, SE, US},
		{SP, C0, US, SE}, {SP, C0, MA, SE}, {C1, C0, SE, US}};

	bsd_strap_model u_bsd_strap_model (
		.ovr_en (ovr_en),
		.ovr_val(ovr_val),
		.pins   (pins)
	);

	bsd_boot_strap_decoder u_bsd_boot_strap_decoder (
		.clk               (clk),
		.srst              (srst),
		.display_data_pins (pins),
		.warm_reset        (warm_reset),
		.strap_status_q    (status),
		.strap_valid_q     (valid),
		.osc_clock_out_en_q(clko),
		.mac_boot_mode_q   (mac),
		.mem_width16_q     (w16),
		.ecc_by_device_q   (ecc),
		.mem_mux_mode_q    (mux),
		.xtal_sel_q        (xtal),
		.rsvd_error_q      (rsvd),
		.boot_dev0_q       (d0),
		.boot_dev1_q       (d1),
		.boot_dev2_q       (d2),
		.boot_dev3_q       (d3),
		.order_known_q     (known)
	);

	// Free-running 250 MHz clock
	always #2 clk = ~clk;

	// Prints the counts and the verdict, then ends the run
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Compares one seen value with its expectation
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask

	// Resets with the given carrier straps and waits for the decode
	task automatic boot(input logic [15:0] en, input logic [15:0] val,
		input logic warm);
		int n;
		@(posedge clk);
		srst <= 1'b1;
		ovr_en <= en;
		ovr_val <= val;
		warm_reset <= warm;
		repeat (3) @(posedge clk);
		#1;
		// outputs held clear while in reset
		check(status, 24'h00_0000);
		check(24'({valid, known, d0, d1, d2, d3}), 24'h00_0000);
		@(posedge clk);
		srst <= 1'b0;
		n = 0;
		while (valid !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20) begin
			n_errors++;
			finish_test();
		end else begin
			#1;
		end
	endtask

	// Checks status layout and every field decode against the pin word
	task automatic fields(input logic [15:0] p);
		check(status, {p[15:8], 8'h00, p[7:0]});
		check(24'(clko), 24'(p[5]));
		check(24'(mac), 24'(p[7:6]));
		check(24'(w16), 24'(p[8]));
		check(24'(ecc), 24'(p[9]));
		check(24'(mux), 24'(p[11:10]));
		check(24'(rsvd), 24'(p[13:12] != 2'h0));
		check(24'(xtal), 24'(p[15:14]));
	endtask

	// Checks the four boot slots and the listed flag
	task automatic order(input logic [15:0] exp, input logic k);
		check(24'({d0, d1, d2, d3}), 24'(exp));
		check(24'(known), 24'(k));
	endtask

	// Untouched module straps give the factory configuration
	task automatic t_default();
		boot(16'h0000, 16'h0000, 1'b0);
		fields(16'h8073);
		order({NA, NI, C0, SE}, 1'b1);
	endtask

	// Every listed order code, set through carrier resistors
	task automatic t_orders();
		for (int i = 0; i < 11; i++) begin
			// carrier changes only the order pins
			boot(16'h001f, {11'h000, codes[i]}, 1'b0);
			order(lists[i], 1'b1);
		end
	endtask

	// Warm reset keeps memory sources and drops peripheral ones
	task automatic t_warm();
		boot(16'h001f, 16'h0017, 1'b1);
		order({C0, SP, 4'h0, 4'h0}, 1'b1);
		boot(16'h001f, 16'h0013, 1'b1);
		order({NA, NI, C0, 4'h0}, 1'b1);
	endtask

	// Codes outside the table give an empty list
	task automatic t_unlisted();
		boot(16'h001f, 16'h0000, 1'b0);
		order(16'h0000, 1'b0);
		boot(16'h001f, 16'h001f, 1'b0);
		order(16'h0000, 1'b0);
	endtask

	// Carrier deliberately drives all pins across three patterns; xtal 11, mux 00, mac mode 01 and reserved 00 are not reached
	task automatic t_fields();
		logic [15:0] pats [3] = '{16'h7fe0, 16'h9513, 16'h2a93};
		for (int i = 0; i < 3; i++) begin
			boot(16'hffff, pats[i], 1'b0);
			fields(pats[i]);
		end
	endtask

	// Pin changes after capture leave the captured word alone
	task automatic t_freeze();
		boot(16'h0000, 16'h0000, 1'b0);
		@(posedge clk);
		ovr_en <= 16'hffff;
		ovr_val <= 16'h3f8c;
		repeat (10) @(posedge clk);
		#1;
		fields(16'h8073);
		check(24'(valid), 24'h00_0001);
	endtask

	// Main sequence
	initial begin
		clk = 1'b0;
		srst = 1'b1;
		warm_reset = 1'b0;
		ovr_en = 16'h0000;
		ovr_val = 16'h0000;
		repeat (20) @(posedge clk);
		t_default();
		t_orders();
		t_warm();
		t_unlisted();
		t_fields();
		t_freeze();
		finish_test();
	end
endmodule
